// File: design/ucs_params.svh
/*
 constants of the serial port control block: register address, bit positions,
 reset value and oversampling figures. assumes nothing; definitions only.
*/
`ifndef UCS_PARAMS_SVH
`define UCS_PARAMS_SVH
// ****************************************
// register map
// ****************************************
`define UCS_SCTRL_ADDR 8'h98
`define UCS_SCTRL_RESET 8'h40
`define UCS_BIT_MODE 3'd7
`define UCS_BIT_UNUSED 3'd6
`define UCS_BIT_MCE 3'd5
`define UCS_BIT_REN 3'd4
`define UCS_BIT_TB8 3'd3
`define UCS_BIT_RB8 3'd2
`define UCS_BIT_TI 3'd1
`define UCS_BIT_RI 3'd0
// ****************************************
// bit timing
// ****************************************
`define UCS_OVS 5'd16
`define UCS_OVS_HALF 5'd8
`define UCS_OVS_LAST 5'd15
`define UCS_DATA_BITS 4'd8
`define UCS_IDLE_LEVEL 1'b1
`endif

// File: design/ucs_pkg.sv
/*
 types of the serial port control block.
 assumes ucs_params.svh is on the include path.
*/
package ucs_pkg;
   typedef enum logic [1:0] {
      UCS_IDLE = 2'b00,
      UCS_START = 2'b01,
      UCS_DATA = 2'b10,
      UCS_STOP = 2'b11
   } ucs_state_t;
   // special-function-register bus access
   typedef struct packed {
      logic [7:0] addr;
      logic wr;
      logic rd;
      logic bit_wr;
      logic [2:0] bit_sel;
      logic [7:0] wdata;
   } ucs_sfr_req_t;
endpackage

// File: design/ucs_ctrl.sv
/*
 control and status of an asynchronous serial port: the control register on the
 sfr bus, a transmit and a receive shifter timed from an outside oversampling tick.
 assumes the data buffer and the tick generator sit outside; the tick is one
 ref_clk cycle wide and runs at sixteen times the baud rate.
*/
`timescale 1ns/1ns
`include "ucs_params.svh"

// What this block does
// - frame_width_select 0 gives 8 data bits and 1 gives 9 data bits, both at a variable rate.
// - bit 6 of serial_control always reads 1 and ignores writes.
// - in 8-bit mode with multiproc check set, rx_done_flag rises only on a stop bit of 1.
// - in 9-bit mode with multiproc check set, rx_done_flag rises only when the ninth bit is 1.
// - a frame is received only if receive_enable_bit is 1 when its start edge is seen.
// - in 9-bit mode tx_ninth_bit is sent as the ninth data bit, otherwise it is unused.
// - rx_ninth_bit takes the stop bit in 8-bit mode and the ninth data bit in 9-bit mode.
// - tx_done_flag sets after the eighth bit in 8-bit mode and at stop bit start in 9-bit mode.
// - tx_done_flag requests the serial interrupt and only software clears it.
// - rx_done_flag sets to 1 when the stop bit is sampled.
// - rx_done_flag requests the serial interrupt and only software clears it.
module ucs_ctrl (
   // clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   // sfr bus
   input wire ucs_pkg::ucs_sfr_req_t sfr_req,
   output logic [7:0] sfr_rdata,
   // data buffer side
   input wire logic tx_load,
   input wire logic [7:0] tx_byte,
   output logic tx_busy,
   output logic [7:0] rx_byte,
   // line and timing
   input wire logic ovs_tick,
   input wire logic rx_line,
   output logic tx_line,
   output logic serial_irq
);
   import ucs_pkg::*;

   // ****************************************
   // control register
   // ****************************************
   logic [7:0] sctrl_q, sctrl_d;
   logic [7:0] rdata_q, rdata_d;
   logic irq_q, irq_d;
   logic tx_set, rx_set, rb8_load, rb8_val;
   logic sel;

   function automatic logic [7:0] bit_merge(input logic [7:0] cur, input ucs_sfr_req_t r);
      logic [7:0] v;
      v = cur;
      if (r.bit_wr) begin
         v[r.bit_sel] = r.wdata[0];
      end else begin
         v = r.wdata;
      end
      return v;
   endfunction

   always_comb begin
      sel = (sfr_req.addr == `UCS_SCTRL_ADDR);
      sctrl_d = sctrl_q;
      if (sel && sfr_req.wr) begin
         sctrl_d = bit_merge(sctrl_q, sfr_req);
      end
      // hardware set wins over a software clear in the same cycle
      if (tx_set) begin
         sctrl_d[`UCS_BIT_TI] = 1'b1;
      end
      if (rx_set) begin
         sctrl_d[`UCS_BIT_RI] = 1'b1;
      end
      if (rb8_load) begin
         sctrl_d[`UCS_BIT_RB8] = rb8_val;
      end
      sctrl_d[`UCS_BIT_UNUSED] = 1'b1;
      rdata_d = rdata_q;
      if (sel && sfr_req.rd) begin
         rdata_d = sctrl_q;
      end else if (sfr_req.rd) begin
         rdata_d = 8'h00;
      end
      irq_d = sctrl_q[`UCS_BIT_TI] | sctrl_q[`UCS_BIT_RI];
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         sctrl_q <= `UCS_SCTRL_RESET;
         rdata_q <= 8'h00;
         irq_q <= 1'b0;
      end else if (clk_en) begin
         sctrl_q <= sctrl_d;
         rdata_q <= rdata_d;
         irq_q <= irq_d;
      end
   end

   logic mode9, mce, ren, tb8;
   always_comb begin
      mode9 = sctrl_q[`UCS_BIT_MODE];
      mce = sctrl_q[`UCS_BIT_MCE];
      ren = sctrl_q[`UCS_BIT_REN];
      tb8 = sctrl_q[`UCS_BIT_TB8];
   end

   function automatic logic [3:0] nbits(input logic m9);
      return m9 ? `UCS_DATA_BITS + 4'd1 : `UCS_DATA_BITS;
   endfunction

   // ****************************************
   // transmitter
   // ****************************************
   ucs_state_t ts_q, ts_d;
   logic [4:0] tph_q, tph_d;
   logic [3:0] tcnt_q, tcnt_d;
   logic [8:0] tsh_q, tsh_d;
   logic txo_q, txo_d;

   always_comb begin
      ts_d = ts_q;
      tph_d = tph_q;
      tcnt_d = tcnt_q;
      tsh_d = tsh_q;
      txo_d = txo_q;
      tx_set = 1'b0;
      unique case (ts_q)
         UCS_IDLE: begin
            txo_d = `UCS_IDLE_LEVEL;
            if (tx_load) begin
               tsh_d = {tb8 & mode9, tx_byte};
               ts_d = UCS_START;
               tph_d = 5'd0;
               txo_d = 1'b0;
            end
         end
         UCS_START: begin
            if (ovs_tick) begin
               tph_d = tph_q + 5'd1;
               if (tph_q == `UCS_OVS_LAST) begin
                  tph_d = 5'd0;
                  ts_d = UCS_DATA;
                  tcnt_d = 4'd0;
                  txo_d = tsh_q[0];
               end
            end
         end
         UCS_DATA: begin
            if (ovs_tick) begin
               tph_d = tph_q + 5'd1;
               if (tph_q == `UCS_OVS_LAST) begin
                  tph_d = 5'd0;
                  tcnt_d = tcnt_q + 4'd1;
                  tsh_d = {1'b0, tsh_q[8:1]};
                  if (tcnt_q + 4'd1 == nbits(mode9)) begin
                     ts_d = UCS_STOP;
                     txo_d = 1'b1;
                     tx_set = 1'b1;
                  end else begin
                     txo_d = tsh_q[1];
                  end
               end
            end
         end
         UCS_STOP: begin
            if (ovs_tick) begin
               tph_d = tph_q + 5'd1;
               if (tph_q == `UCS_OVS_LAST) begin
                  ts_d = UCS_IDLE;
               end
            end
         end
      endcase
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ts_q <= UCS_IDLE;
         tph_q <= 5'd0;
         tcnt_q <= 4'd0;
         tsh_q <= 9'h000;
         txo_q <= 1'b1;
      end else if (clk_en) begin
         ts_q <= ts_d;
         tph_q <= tph_d;
         tcnt_q <= tcnt_d;
         tsh_q <= tsh_d;
         txo_q <= txo_d;
      end
   end

   // ****************************************
   // receiver
   // ****************************************
   ucs_state_t rs_q, rs_d;
   logic [4:0] rph_q, rph_d;
   logic [3:0] rcnt_q, rcnt_d;
   logic [8:0] rsh_q, rsh_d;
   logic [7:0] rxb_q, rxb_d;
   logic accept;
   logic rprev_q, rprev_d;

   always_comb begin
      rs_d = rs_q;
      rph_d = rph_q;
      rcnt_d = rcnt_q;
      rsh_d = rsh_q;
      rxb_d = rxb_q;
      rprev_d = ovs_tick ? rx_line : rprev_q;
      rx_set = 1'b0;
      rb8_load = 1'b0;
      rb8_val = 1'b0;
      accept = 1'b0;
      unique case (rs_q)
         UCS_IDLE: begin
            // start needs a falling edge: a low stop bit must not open a false frame
            if (ren && rprev_q && !rx_line && ovs_tick) begin
               rs_d = UCS_START;
               rph_d = 5'd1;
            end
         end
         UCS_START: begin
            if (ovs_tick) begin
               rph_d = rph_q + 5'd1;
               if (rph_q == `UCS_OVS_HALF - 5'd1) begin
                  if (rx_line) begin
                     rs_d = UCS_IDLE;
                  end else begin
                     rph_d = 5'd0;
                     rcnt_d = 4'd0;
                     rs_d = UCS_DATA;
                  end
               end
            end
         end
         UCS_DATA: begin
            if (ovs_tick) begin
               rph_d = rph_q + 5'd1;
               if (rph_q == `UCS_OVS_LAST) begin
                  rph_d = 5'd0;
                  rsh_d = mode9 ? {rx_line, rsh_q[8:1]} : {1'b0, rx_line, rsh_q[7:1]};
                  rcnt_d = rcnt_q + 4'd1;
                  if (rcnt_q + 4'd1 == nbits(mode9)) begin
                     rs_d = UCS_STOP;
                  end
               end
            end
         end
         UCS_STOP: begin
            if (ovs_tick) begin
               rph_d = rph_q + 5'd1;
               if (rph_q == `UCS_OVS_LAST) begin
                  rs_d = UCS_IDLE;
                  if (mode9) begin
                     accept = !mce || rsh_q[8];
                     rb8_val = rsh_q[8];
                  end else begin
                     accept = !mce || rx_line;
                     rb8_val = rx_line;
                  end
                  if (accept) begin
                     rx_set = 1'b1;
                     rb8_load = 1'b1;
                     rxb_d = rsh_q[7:0];
                  end
               end
            end
         end
      endcase
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rs_q <= UCS_IDLE;
         rph_q <= 5'd0;
         rcnt_q <= 4'd0;
         rsh_q <= 9'h000;
         rxb_q <= 8'h00;
         rprev_q <= `UCS_IDLE_LEVEL;
      end else if (clk_en) begin
         rs_q <= rs_d;
         rph_q <= rph_d;
         rcnt_q <= rcnt_d;
         rsh_q <= rsh_d;
         rxb_q <= rxb_d;
         rprev_q <= rprev_d;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   logic busy_q;
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         busy_q <= 1'b0;
      end else if (clk_en) begin
         busy_q <= (ts_d != UCS_IDLE);
      end
   end

   always_comb begin
      sfr_rdata = rdata_q;
      tx_line = txo_q;
      serial_irq = irq_q;
      tx_busy = busy_q;
      rx_byte = rxb_q;
   end
endmodule

// File: tb/ucs_ctrl_monitor.sv
/*
 port assertions of the serial control block.
 assumes it is bound to ucs_ctrl and clk_en is mostly high.
*/
`timescale 1ns/1ns
// ****
// checker
// ****
module ucs_ctrl_monitor (
   // clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   // bus, line and flags
   input wire ucs_pkg::ucs_sfr_req_t sfr_req,
   input wire logic [7:0] sfr_rdata,
   input wire logic tx_load,
   input wire logic tx_busy,
   input wire logic tx_line,
   input wire logic serial_irq
);
   import ucs_pkg::*;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   sequence rd_reg;
      clk_en && sfr_req.rd && sfr_req.addr == 8'h98;
   endsequence
   sequence tx_go;
      clk_en && tx_load && !tx_busy;
   endsequence
   fixed_bit_a: assert property (rd_reg |=> sfr_rdata[6])
      else $error("bit 6 read as 0");
   unmapped_a: assert property (clk_en && sfr_req.rd && sfr_req.addr != 8'h98
      |=> sfr_rdata == 8'h00) else $error("unmapped read not 0");
   read_hold_a: assert property (!sfr_req.rd |=> $stable(sfr_rdata))
      else $error("read data moved without a read");
   start_bit_a: assert property (tx_go |=> !tx_line && tx_busy)
      else $error("no start bit after load");
   start_hold_a: assert property ($rose(tx_busy) |-> !tx_line [*8])
      else $error("start bit too short");
   idle_high_a: assert property (!tx_busy |-> tx_line)
      else $error("line low while idle");
   stop_high_a: assert property ($fell(tx_busy) |-> tx_line && $past(tx_line))
      else $error("frame ended without stop level");
   irq_clear_a: assert property ($fell(serial_irq) |->
      $past(sfr_req.wr || sfr_req.bit_wr, 2))
      else $error("flag cleared without a write");
endmodule

bind ucs_ctrl ucs_ctrl_monitor i_mon (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en),
   .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .tx_load(tx_load), .tx_busy(tx_busy),
   .tx_line(tx_line), .serial_irq(serial_irq));

// File: tb/ucs_node_model.sv
/*
 remote serial node: sends frames on rx_line, captures frames from tx_line.
 assumes ovs_tick runs at sixteen times the baud rate.
*/
`timescale 1ns/1ns
module ucs_node_model (
   // timing
   input wire logic ref_clk,
   input wire logic ovs_tick,
   // line
   input wire logic tx_line,
   output logic rx_line
);
   logic [8:0] got_word;
   int got_count;
   task automatic ticks(input int n);
      repeat (n) @(posedge ref_clk iff ovs_tick);
   endtask
   // start, data lsb first, ninth bit if asked, stop, one idle slot in 8-bit frames only
   task automatic send(input logic [7:0] d, input logic nine, input logic b9, input logic stp);
      logic [10:0] f;
      f = nine ? {stp, b9, d, 1'b0} : {1'b1, stp, d, 1'b0};
      for (int i = 0; i < 11; i++) begin
         rx_line <= f[i];
         ticks(16);
      end
   endtask
   // nine samples: in 8-bit frames the last one is the stop level
   initial begin
      rx_line = 1'b1;
      got_count = 0;
      forever begin
         @(negedge tx_line);
         ticks(8);
         for (int i = 0; i < 9; i++) begin
            ticks(16);
            got_word[i] = tx_line;
         end
         got_count++;
      end
   end
endmodule

// File: tb/testbench.sv
/*
 bench of the serial control block: bus tasks, transmit and receive cases.
 assumes the node model and the monitor are compiled with the design.
*/
`timescale 1ns/1ns
module testbench;
   import ucs_pkg::*;
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic ovs_tick = 1'b0;
   ucs_sfr_req_t sfr_req = '0;
   logic tx_load = 1'b0;
   logic [7:0] tx_byte = 8'h00;
   logic clk_en = 1'b1;
   logic [7:0] sfr_rdata, rx_byte;
   logic tx_busy, tx_line, rx_line, serial_irq;
   int fail_count = 0;
   int samples_checked = 0;
   logic [7:0] rc [7] = '{8'h20, 8'h30, 8'h30, 8'h10, 8'hB0, 8'hB0, 8'h90};
   logic [6:0] b9s = 7'b0010000;
   logic [6:0] sts = 7'b1110101;
   ucs_ctrl i_ucs_ctrl (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en), .sfr_req(sfr_req),
      .sfr_rdata(sfr_rdata), .tx_load(tx_load), .tx_byte(tx_byte), .tx_busy(tx_busy),
      .rx_byte(rx_byte), .ovs_tick(ovs_tick), .rx_line(rx_line), .tx_line(tx_line),
      .serial_irq(serial_irq));
   ucs_node_model i_ucs_node_model (.ref_clk(ref_clk), .ovs_tick(ovs_tick),
      .tx_line(tx_line), .rx_line(rx_line));
   initial begin
      forever #25 ref_clk = ~ref_clk;
   end
   // a tick every other cycle keeps frames short
   always @(posedge ref_clk) ovs_tick <= ~ovs_tick;
   task automatic check(input logic [8:0] seen, input logic [8:0] want);
      samples_checked++;
      if (seen !== want) begin
         fail_count++;
         $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, want);
      end
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      sfr_req <= {a, 3'h4, 3'h0, d};
      @(posedge ref_clk);
      sfr_req <= '0;
   endtask
   // single bit write to serial_control
   task automatic bwr(input logic [2:0] s, input logic v);
      @(posedge ref_clk);
      sfr_req <= {8'h98, 3'h5, s, 7'h00, v};
      @(posedge ref_clk);
      sfr_req <= '0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] want);
      @(posedge ref_clk);
      sfr_req <= {a, 3'h2, 3'h0, 8'h00};
      @(posedge ref_clk);
      sfr_req <= '0;
      @(negedge ref_clk);
      check({1'b0, sfr_rdata}, {1'b0, want});
   endtask
   task automatic tx_frame(input logic [7:0] b);
      int n;
      n = 0;
      @(posedge ref_clk);
      tx_byte <= b;
      tx_load <= 1'b1;
      @(posedge ref_clk);
      tx_load <= 1'b0;
      @(posedge ref_clk);
      while (tx_busy === 1'b1 && n < 2000) begin
         @(posedge ref_clk);
         n++;
      end
      if (n == 2000) begin
         check(9'h001, 9'h000);
         conclude();
      end
   endtask
   initial begin
      logic acc;
      logic r8;
      repeat (5) @(posedge ref_clk);
      sys_rst <= 1'b0;
      rd(8'h98, 8'h40);
      rd(8'h99, 8'h00);
      wr(8'h98, 8'h10);
      tx_frame(8'hA5);
      check(i_ucs_node_model.got_word, 9'h1A5);
      check(9'(i_ucs_node_model.got_count), 9'd1);
      rd(8'h98, 8'h52);
      check({8'h00, serial_irq}, 9'h001);
      wr(8'h98, 8'h10);
      rd(8'h98, 8'h50);
      check({8'h00, serial_irq}, 9'h000);
      wr(8'h98, 8'h98);
      tx_frame(8'h3C);
      check(i_ucs_node_model.got_word, 9'h13C);
      check(9'(i_ucs_node_model.got_count), 9'd2);
      rd(8'h98, 8'hDA);
      // receive: enable, mode and multiprocessor check against stop and ninth levels
      for (int k = 0; k < 7; k++) begin
         wr(8'h98, rc[k]);
         i_ucs_node_model.send(8'(8'hC3 + k), rc[k][7], b9s[k], sts[k]);
         r8 = rc[k][7] ? b9s[k] : sts[k];
         acc = rc[k][4] && (!rc[k][5] || r8);
         rd(8'h98, rc[k] | 8'h40 | (acc ? {5'h00, r8, 2'b01} : 8'h00));
         if (acc) check({1'b0, rx_byte}, {1'b0, 8'(8'hC3 + k)});
         check({8'h00, serial_irq}, {8'h00, acc});
      end
      // a low clock enable must drop a write outright
      @(posedge ref_clk);
      clk_en <= 1'b0;
      wr(8'h98, 8'h00);
      clk_en <= 1'b1;
      rd(8'h98, 8'hD1);
      // bit writes: the ninth transmit bit sets, bit 6 refuses a zero
      bwr(3'd3, 1'b1);
      bwr(3'd6, 1'b0);
      rd(8'h98, 8'hD9);
      conclude();
   end
endmodule
